// ---- verilog/scit_clock_timer.sv ----
// System clock selector, divider, stop control and basic interval timer.
// Assumes oscillator outputs arrive as plain levels and are sampled here;
// registers are reached over AXI4-Lite on sys_clk_i.
//
// Contract
// (R1) Reset selects internal RC, divide by one
// (R2) Divide field gives RC over 1,2,4,8
// (R3) Source field picks RC, crystal, sub, ring
// (R4) Bypass set: switch now; else at wake
// (R5) RC halt honoured only with bypass set
// (R6) Crystal halt resets set, needs bypass set
// (R7) Stop-select chooses deep or light stop
// (R8) Interval timer runs from ring oscillator
// (R9) Interval counter is free running, unstoppable
// (R10) Clear bit zeroes counter, self-clears later
// (R11) Selected period elapsing sets overflow flag
// (R12) Period field doubles from 0.512 ms
// (R13) Count register reads counter, resets zero
// (R14) Overflow is the watchdog time base
// (R15) Overflow wait at power-on and wake
// (R16) Clock control register resets to 04H
// (R17) Writing zero clears overflow flag
// (R18) Source changes never shorten clock pulses
`timescale 1ns/1ps
module scit_clock_timer (
	input  wire logic                        sys_clk_i,
	input  wire logic                        srst_i,
	input  wire logic                        rc_osc_i,
	input  wire logic                        xtal_osc_i,
	input  wire logic                        sub_osc_i,
	input  wire logic                        ring_osc_i,
	input  wire logic                        wake_i,
	input  wire logic                        crystal_fuse_allow_i,
	input  wire logic [7:0]                  power_control_i,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [scit_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	output logic [1:0]                       s_axi_bresp,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	input  wire logic [scit_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             sys_clk_o,
	output logic                             sys_clk_ready_o,
	output logic                             rc_osc_en_o,
	output logic                             xtal_osc_en_o,
	output logic                             stop_o,
	output logic                             deep_stop_select_o,
	output logic                             watchdog_tick_o,
	output logic                             irq_o
);
	typedef struct packed {
		logic                     aw_ok;
		logic [7:0]               aw_idx;
		logic                     w_ok;
		logic [7:0]               wdat;
		logic                     wlane;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     rvalid;
		logic [31:0]              rdata;
		logic [1:0]               rresp;
		logic [7:0]               clk_ctrl;
		logic [2:0]               period;
		logic                     flag;
		logic [1:0]               clr_cnt;
		logic [7:0]               bit_cnt;
		logic [7:0]               pre_cnt;
		logic [1:0]               irq_stat;
		logic [1:0]               irq_mask;
		logic [4:0]               s1;
		logic [4:0]               s2;
		logic [4:0]               prv;
		logic [2:0]               rc_cnt;
		logic [1:0]               src;
		logic [1:0]               div;
		logic [1:0]               tgt_src;
		logic [1:0]               tgt_div;
		logic                     pend;
		logic                     rc_halt;
		logic                     xt_halt;
		logic                     clk_out;
		logic                     wd_tick;
		logic                     deep;
		scit_pkg::scit_state_e    state;
	} scit_regs_s;

	scit_regs_s q;
	scit_regs_s next_q;

	logic [4:0] raw_in;
	logic [4:0] rise;
	logic       bit_tick;
	logic       ovf;
	logic [7:0] low_mask;
	logic       wr_fire;
	logic       run;
	logic       cur_lvl;
	logic       tgt_lvl;
	logic [7:0] ridx;

	assign raw_in = {wake_i, ring_osc_i, sub_osc_i, xtal_osc_i, rc_osc_i};

	// Level of a source at a given divide setting
	function automatic logic src_level(input logic [1:0] s, input logic [1:0] d,
		input logic [4:0] lv, input logic [2:0] rc);
		logic r;
		r = (d == 2'h0) ? lv[0] : rc[d - 2'h1];             // [R2]
		unique case (s)                                      // [R3]
			scit_pkg::SRC_RC:   src_level = r;
			scit_pkg::SRC_XTAL: src_level = lv[1];
			scit_pkg::SRC_SUB:  src_level = lv[2];
			scit_pkg::SRC_RING: src_level = lv[3];
		endcase
	endfunction : src_level

	always_comb
	begin
		next_q  = q;
		rise    = q.s2 & ~q.prv;
		run     = (q.state == scit_pkg::ST_RUN);
		ridx    = s_axi_araddr[9:2];
		// Synchronisers and edge history
		next_q.s1  = raw_in;
		next_q.s2  = q.s1;
		next_q.prv = q.s2;

		// Ring-clocked prescaler and free-running counter
		bit_tick = rise[3] && (q.pre_cnt == scit_pkg::RING_PRESCALE_MAX); // [R8]
		low_mask = ~(8'hFE << q.period);                                 // [R12]
		ovf      = bit_tick && ((q.bit_cnt | ~low_mask) == 8'hFF);       // [R11]
		if (rise[3])
			next_q.pre_cnt = q.pre_cnt + 8'h01;
		if (bit_tick)
			next_q.bit_cnt = q.bit_cnt + 8'h01;                          // [R9]
		next_q.wd_tick = ovf;                                            // [R14]
		if (q.clr_cnt != 2'h0)
			next_q.clr_cnt = q.clr_cnt - 2'h1;                           // [R10]

		// RC divider
		if (rise[0])
			next_q.rc_cnt = q.rc_cnt + 3'h1;

		// Glitch-free output: finish the old high phase, hold low, move when both low
		cur_lvl = src_level(q.src, q.div, q.s2, q.rc_cnt);
		tgt_lvl = src_level(q.tgt_src, q.tgt_div, q.s2, q.rc_cnt);
		if (q.pend)
		begin
			next_q.clk_out = q.clk_out && cur_lvl && run;                // [R18]
			if (!q.clk_out && !tgt_lvl)
			begin
				next_q.src  = q.tgt_src;
				next_q.div  = q.tgt_div;
				next_q.pend = 1'b0;
			end
		end
		else
			next_q.clk_out = cur_lvl && run;

		// Stop and warm-up sequencing
		unique case (q.state)
			scit_pkg::ST_RUN:
				if (power_control_i == scit_pkg::POWER_STOP)
				begin
					next_q.state = scit_pkg::ST_STOP;
					next_q.deep  = q.clk_ctrl[scit_pkg::CLKCTL_DEEP_STOP]; // [R7]
				end
			scit_pkg::ST_STOP:
				if (q.s2[4])
				begin
					next_q.state = scit_pkg::ST_WARM;
					if (!q.clk_ctrl[scit_pkg::CLKCTL_BYPASS])
					begin
						next_q.tgt_src = q.clk_ctrl[scit_pkg::CLKCTL_SRC_LSB +: 2]; // [R4]
						next_q.tgt_div = q.clk_ctrl[scit_pkg::CLKCTL_DIV_LSB +: 2];
						next_q.pend    = 1'b1;
					end
				end
			scit_pkg::ST_WARM:
				if (ovf)
				begin
					next_q.state = scit_pkg::ST_RUN;                     // [R15]
					next_q.irq_stat[scit_pkg::IRQ_RESUMED] = 1'b1;
				end
		endcase

		// AXI write channel
		if (s_axi_awvalid && !q.aw_ok)
		begin
			next_q.aw_ok  = 1'b1;
			next_q.aw_idx = s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid && !q.w_ok)
		begin
			next_q.w_ok  = 1'b1;
			next_q.wdat  = s_axi_wdata[7:0];
			next_q.wlane = s_axi_wstrb[0];
		end
		wr_fire = q.aw_ok && q.w_ok && !q.bvalid;
		if (wr_fire)
		begin
			next_q.aw_ok  = 1'b0;
			next_q.w_ok   = 1'b0;
			next_q.bvalid = 1'b1;
			next_q.bresp  = scit_pkg::RESP_OKAY;
			unique case (q.aw_idx)
				scit_pkg::IDX_SYS_CLOCK_CONTROL:
					if (q.wlane)
					begin
						next_q.clk_ctrl = q.wdat;
						if (q.wdat[scit_pkg::CLKCTL_BYPASS])
						begin
							next_q.tgt_src = q.wdat[scit_pkg::CLKCTL_SRC_LSB +: 2]; // [R4]
							next_q.tgt_div = q.wdat[scit_pkg::CLKCTL_DIV_LSB +: 2];
							next_q.pend    = 1'b1;
							next_q.rc_halt = q.wdat[scit_pkg::CLKCTL_RC_HALT];      // [R5]
							next_q.xt_halt = q.wdat[scit_pkg::CLKCTL_XT_HALT]
								|| !crystal_fuse_allow_i;                         // [R6]
						end
					end
				scit_pkg::IDX_INTERVAL_CONTROL:
					if (q.wlane)
					begin
						next_q.period = q.wdat[scit_pkg::TMRCTL_PERIOD_LSB +: 3];
						if (!q.wdat[scit_pkg::TMRCTL_FLAG])
							next_q.flag = 1'b0;                                   // [R17]
						if (q.wdat[scit_pkg::TMRCTL_CLEAR])
						begin
							next_q.bit_cnt = scit_pkg::COUNT_RESET;               // [R10]
							next_q.pre_cnt = 8'h00;
							next_q.clr_cnt = scit_pkg::MACHINE_CYCLES;
						end
					end
				scit_pkg::IDX_INTERVAL_COUNT: ;
				scit_pkg::IDX_IRQ_STATUS:
					if (q.wlane)
						next_q.irq_stat = next_q.irq_stat & ~q.wdat[1:0];
				scit_pkg::IDX_IRQ_MASK:
					if (q.wlane)
						next_q.irq_mask = q.wdat[1:0];
				default:
					next_q.bresp = scit_pkg::RESP_SLVERR;
			endcase
		end
		if (q.bvalid && s_axi_bready)
			next_q.bvalid = 1'b0;

		// Hardware events win over software clears
		if (ovf)
		begin
			next_q.flag = 1'b1;                                          // [R11]
			next_q.irq_stat[scit_pkg::IRQ_OVERFLOW] = 1'b1;
		end
		if (ovf && q.state == scit_pkg::ST_WARM)
			next_q.irq_stat[scit_pkg::IRQ_RESUMED] = 1'b1;

		// AXI read channel
		if (s_axi_arvalid && !q.rvalid)
		begin
			next_q.rvalid = 1'b1;
			next_q.rresp  = scit_pkg::RESP_OKAY;
			next_q.rdata  = 32'h0000_0000;
			unique case (ridx)
				scit_pkg::IDX_SYS_CLOCK_CONTROL:
					next_q.rdata[7:0] = q.clk_ctrl;
				scit_pkg::IDX_INTERVAL_CONTROL:
				begin
					next_q.rdata[scit_pkg::TMRCTL_FLAG]  = q.flag;
					next_q.rdata[scit_pkg::TMRCTL_CLEAR] = (q.clr_cnt != 2'h0);
					next_q.rdata[scit_pkg::TMRCTL_PERIOD_LSB +: 3] = q.period;
				end
				scit_pkg::IDX_INTERVAL_COUNT:
					next_q.rdata[7:0] = q.bit_cnt;                       // [R13]
				scit_pkg::IDX_IRQ_STATUS:
					next_q.rdata[1:0] = q.irq_stat;
				scit_pkg::IDX_IRQ_MASK:
					next_q.rdata[1:0] = q.irq_mask;
				default:
					next_q.rresp = scit_pkg::RESP_SLVERR;
			endcase
		end
		else if (q.rvalid && s_axi_rready)
			next_q.rvalid = 1'b0;

		// Synchronous reset
		if (srst_i)
		begin
			next_q          = '0;
			next_q.clk_ctrl = scit_pkg::CLKCTL_RESET;                    // [R16]
			next_q.period   = scit_pkg::TMRCTL_RESET[scit_pkg::TMRCTL_PERIOD_LSB +: 3];
			next_q.bit_cnt  = scit_pkg::COUNT_RESET;                     // [R13]
			next_q.src      = scit_pkg::SRC_RC;                          // [R1]
			next_q.tgt_src  = scit_pkg::SRC_RC;
			next_q.xt_halt  = 1'b1;                                      // [R6]
			next_q.state    = scit_pkg::ST_WARM;                         // [R15]
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		q <= next_q;
	end

	assign s_axi_awready      = !q.aw_ok;
	assign s_axi_wready       = !q.w_ok;
	assign s_axi_bvalid       = q.bvalid;
	assign s_axi_bresp        = q.bresp;
	assign s_axi_arready      = !q.rvalid;
	assign s_axi_rvalid       = q.rvalid;
	assign s_axi_rdata        = q.rdata;
	assign s_axi_rresp        = q.rresp;
	assign sys_clk_o          = q.clk_out;
	assign sys_clk_ready_o    = (q.state == scit_pkg::ST_RUN);
	assign rc_osc_en_o        = !q.rc_halt && (q.state != scit_pkg::ST_STOP);
	assign xtal_osc_en_o      = !q.xt_halt && crystal_fuse_allow_i
		&& (q.state != scit_pkg::ST_STOP);
	assign stop_o             = (q.state == scit_pkg::ST_STOP);
	assign deep_stop_select_o = q.deep;                                  // [R7]
	assign watchdog_tick_o    = q.wd_tick;                               // [R14]
	assign irq_o              = |(q.irq_stat & q.irq_mask);
endmodule : scit_clock_timer

// ---- verilog/scit_pkg.sv ----
// Constants for the system clock control and interval timer block.
// Assumes a 10 MHz system clock and an AXI4-Lite master with 32-bit data.
package scit_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_SYS_CLOCK_CONTROL = 8'h8A;
	localparam logic [7:0] IDX_INTERVAL_CONTROL  = 8'h8B;
	localparam logic [7:0] IDX_INTERVAL_COUNT    = 8'h8C;
	localparam logic [7:0] IDX_IRQ_STATUS        = 8'h90;
	localparam logic [7:0] IDX_IRQ_MASK          = 8'h91;
	localparam int         ADDR_W                = 12;

	// Reset values
	localparam logic [7:0] CLKCTL_RESET = 8'h04;
	localparam logic [7:0] TMRCTL_RESET = 8'h05;
	localparam logic [7:0] COUNT_RESET  = 8'h00;

	// System clock control fields
	localparam int CLKCTL_DEEP_STOP = 7;
	localparam int CLKCTL_DIV_LSB   = 5;
	localparam int CLKCTL_BYPASS    = 4;
	localparam int CLKCTL_RC_HALT   = 3;
	localparam int CLKCTL_XT_HALT   = 2;
	localparam int CLKCTL_SRC_LSB   = 0;

	// Interval timer control fields
	localparam int TMRCTL_FLAG       = 7;
	localparam int TMRCTL_CLEAR      = 3;
	localparam int TMRCTL_PERIOD_LSB = 0;

	// Interrupt status bits
	localparam int IRQ_OVERFLOW = 0;
	localparam int IRQ_RESUMED  = 1;

	// Clock source codes
	localparam logic [1:0] SRC_RC   = 2'h0;
	localparam logic [1:0] SRC_XTAL = 2'h1;
	localparam logic [1:0] SRC_SUB  = 2'h2;
	localparam logic [1:0] SRC_RING = 2'h3;

	// Power control value that requests stop
	localparam logic [7:0] POWER_STOP = 8'h03;

	// Timing
	localparam int         CLK_PERIOD_NS     = 100;
	localparam int         MACHINE_CYCLE_NS  = 200;
	localparam logic [1:0] MACHINE_CYCLES    =
		2'((MACHINE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] RING_PRESCALE_MAX = 8'hFF;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WARM} scit_state_e;
endpackage : scit_pkg

// ---- test/scit_clock_timer_props.sv ----
// Assertion checker for the clock control and interval timer block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module scit_clock_timer_props (
	input wire logic       sys_clk_i,
	input wire logic       srst_i,
	input wire logic [7:0] power_control_i,
	input wire logic       sys_clk_o,
	input wire logic       sys_clk_ready_o,
	input wire logic       rc_osc_en_o,
	input wire logic       xtal_osc_en_o,
	input wire logic       stop_o,
	input wire logic       watchdog_tick_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	property p_reset_out;
		$fell(srst_i) |-> !sys_clk_ready_o && !stop_o && rc_osc_en_o && !xtal_osc_en_o && !sys_clk_o;
	endproperty
	a_reset_out: assert property (p_reset_out)
		else $error("outputs wrong after reset");
	property p_tick_pulse;
		watchdog_tick_o |=> !watchdog_tick_o;
	endproperty
	a_tick_pulse: assert property (p_tick_pulse)
		else $error("tick longer than one cycle");
	property p_stop_entry;
		sys_clk_ready_o && power_control_i == 8'h03 |=> stop_o;
	endproperty
	a_stop_entry: assert property (p_stop_entry)
		else $error("stop not entered");
	property p_stop_ready;
		stop_o |-> !sys_clk_ready_o;
	endproperty
	a_stop_ready: assert property (p_stop_ready)
		else $error("ready high in stop");
	property p_wake_warm;
		$fell(stop_o) |-> !sys_clk_ready_o;
	endproperty
	a_wake_warm: assert property (p_wake_warm)
		else $error("no settling wait after stop");
	property p_ready_rise;
		$rose(sys_clk_ready_o) |-> watchdog_tick_o || $past(watchdog_tick_o)
			|| $past(watchdog_tick_o, 2);
	endproperty
	a_ready_rise: assert property (p_ready_rise)
		else $error("ready rose without overflow");
	property p_clk_idle;
		!sys_clk_ready_o && !$past(sys_clk_ready_o) |-> !sys_clk_o;
	endproperty
	a_clk_idle: assert property (p_clk_idle)
		else $error("clock runs outside run state");
	property p_osc_off;
		stop_o && $past(stop_o) |-> !rc_osc_en_o && !xtal_osc_en_o;
	endproperty
	a_osc_off: assert property (p_osc_off)
		else $error("oscillator enabled in stop");
	property p_clk_pulse;
		$rose(sys_clk_o) && sys_clk_ready_o |=> sys_clk_o;
	endproperty
	a_clk_pulse: assert property (p_clk_pulse)
		else $error("short clock pulse");
endmodule : scit_clock_timer_props

// ---- test/scit_clock_timer_tb.sv ----
// Self-checking bench for the clock control and interval timer block.
// Assumes the package is compiled first; bench drives bus and oscillators.
`timescale 1ns/1ps
module scit_clock_timer_tb;
	logic        sys_clk_i, srst_i, rc_osc_i, xtal_osc_i, sub_osc_i, ring_osc_i;
	logic        wake_i, crystal_fuse_allow_i, s_axi_awvalid, s_axi_awready;
	logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        sys_clk_o, sys_clk_ready_o, rc_osc_en_o, xtal_osc_en_o, stop_o;
	logic        deep_stop_select_o, watchdog_tick_o, irq_o;
	logic [7:0]  power_control_i;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
	logic [5:0]  osc_cnt = 6'h00;
	int          fail_count, n_checks;

	scit_clock_timer scit_clock_timer_inst (.*);

	initial
	begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	// Slow oscillators: periods of 8, 32, 64 and 16 clocks
	always @(posedge sys_clk_i)
	begin
		osc_cnt    <= osc_cnt + 6'h01;
		rc_osc_i   <= osc_cnt[2];
		xtal_osc_i <= osc_cnt[4];
		sub_osc_i  <= osc_cnt[5];
		ring_osc_i <= osc_cnt[3];
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic results();
		if (fail_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	task automatic timeout();
		fail_count++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		results();
	endtask : timeout

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		int n;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_awaddr  <= {2'h0, idx, 2'h0};
		s_axi_wdata   <= {24'h000000, d};
		s_axi_bready  <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge sys_clk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 50) timeout();
		wr_resp = s_axi_bresp;
	endtask : wr

	task automatic rd(input logic [7:0] idx);
		int n;
		s_axi_arvalid <= 1'b1;
		s_axi_araddr  <= {2'h0, idx, 2'h0};
		s_axi_rready  <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge sys_clk_i);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 50) timeout();
		rd_data = s_axi_rdata;
		rd_resp = s_axi_rresp;
	endtask : rd

	task automatic wait_tick(output int cyc);
		for (cyc = 0; cyc < 20000; cyc++)
		begin
			@(posedge sys_clk_i);
			if (watchdog_tick_o === 1'b1) break;
		end
		if (cyc == 20000) timeout();
	endtask : wait_tick

	task automatic measure(input int exp);
		int   cnt;
		logic prev;
		cnt = 0;
		repeat (200) @(posedge sys_clk_i);
		prev = sys_clk_o;
		repeat (1024)
		begin
			@(posedge sys_clk_i);
			if (sys_clk_o && !prev) cnt++;
			prev = sys_clk_o;
		end
		chk(32'(cnt >= exp - 2 && cnt <= exp + 2), 32'h1);
	endtask : measure

	task automatic t_reset();
		chk({rc_osc_en_o, xtal_osc_en_o, deep_stop_select_o, irq_o}, 32'h8);
		rd(8'h8A);
		chk(rd_data, 32'h04);
		rd(8'h8B);
		chk(rd_data, 32'h05);
		wr(8'h8C, 8'h55);
		chk(wr_resp, scit_pkg::RESP_OKAY);
		rd(8'h8C);
		chk(rd_data, 32'h00);
		rd(8'h00);
		chk(rd_resp, scit_pkg::RESP_SLVERR);
		wr(8'h00, 8'h00);
		chk(wr_resp, scit_pkg::RESP_SLVERR);
	endtask : t_reset

	task automatic t_overflow();
		int p, cyc;
		for (p = 1; p >= 0; p--)
		begin
			wr(8'h8B, 8'(p));
			wait_tick(cyc);
			wait_tick(cyc);
			chk(32'(cyc > (8192 << p) - 40 && cyc < (8192 << p) + 40), 32'h1);
		end
		chk(sys_clk_ready_o, 32'h1);
		rd(8'h8B);
		chk(rd_data, 32'h80);
		chk(irq_o, 32'h0);
		wr(8'h91, 8'h01);
		repeat (2) @(posedge sys_clk_i);
		chk(irq_o, 32'h1);
		wr(8'h8B, 8'h80);
		rd(8'h8B);
		chk(rd_data, 32'h80);
		wr(8'h8B, 8'h00);
		rd(8'h8B);
		chk(rd_data, 32'h00);
		wr(8'h90, 8'h01);
		repeat (2) @(posedge sys_clk_i);
		chk(irq_o, 32'h0);
	endtask : t_overflow

	task automatic t_clear();
		wr(8'h8B, 8'h08);
		rd(8'h8C);
		chk(rd_data, 32'h00);
		repeat (4) @(posedge sys_clk_i);
		rd(8'h8B);
		chk(rd_data, 32'h00);
		repeat (4200) @(posedge sys_clk_i);
		rd(8'h8C);
		chk(32'(rd_data != 32'h0), 32'h1);
	endtask : t_clear

	task automatic t_osc();
		int i;
		int src_exp[4] = '{128, 32, 16, 64};
		wr(8'h8A, 8'h08);
		chk(rc_osc_en_o, 32'h1);
		wr(8'h8A, 8'h00);
		chk(xtal_osc_en_o, 32'h0);
		wr(8'h8A, 8'h19);
		repeat (2) @(posedge sys_clk_i);
		chk({rc_osc_en_o, xtal_osc_en_o}, 32'h1);
		for (i = 0; i < 4; i++)
		begin
			wr(8'h8A, 8'h10 | 8'(i));
			measure(src_exp[i]);
		end
		for (i = 0; i < 4; i++)
		begin
			wr(8'h8A, 8'h10 | 8'(i << 5));
			measure(128 >> i);
		end
		wr(8'h8A, 8'h10);
	endtask : t_osc

	task automatic t_stop();
		int n;
		wr(8'h8A, 8'h83);
		measure(128);
		power_control_i <= 8'h03;
		for (n = 0; n < 10; n++)
		begin
			@(posedge sys_clk_i);
			if (stop_o) break;
		end
		chk(stop_o, 32'h1);
		chk(deep_stop_select_o, 32'h1);
		power_control_i <= 8'h00;
		wake_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		wake_i <= 1'b0;
		for (n = 0; n < 20000; n++)
		begin
			@(posedge sys_clk_i);
			if (sys_clk_ready_o) break;
		end
		if (n == 20000) timeout();
		measure(64);
		rd(8'h90);
		chk(rd_data[1], 32'h1);
		wr(8'h90, 8'h03);
	endtask : t_stop

	initial
	begin
		{srst_i, crystal_fuse_allow_i} = 2'b11;
		wake_i = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hF;
		power_control_i = 8'h00;
		fail_count = 0;
		n_checks = 0;
		repeat (20) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		@(posedge sys_clk_i);
		t_reset();
		t_overflow();
		t_clear();
		t_osc();
		t_stop();
		results();
	end
endmodule : scit_clock_timer_tb

bind scit_clock_timer scit_clock_timer_props scit_clock_timer_props_inst (.*);
